// ### hdl/cop_follower_end.sv
`timescale 1ns/10ps
module cop_follower_end
    import cop_port_pkg::*;
#(
    parameter logic [3:0] COP_NUM = DEFAULT_COP_NUM,
    parameter int NUM_REGS = 16,
    parameter int LONG_WAITS = LONG_OP_WAITS
)
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Port towards the core
    cop_port_if.coproc port,
    // Local status
    input wire logic COP_BUSY,
    // Committed register writes
    output logic REG_WRITE,
    output logic [REG_FIELD_W-1:0] REG_INDEX,
    output logic [WORD_W-1:0] REG_DATA
);

    logic [WORD_W-1:0] regs_q [NUM_REGS];
    logic [WORD_W-1:0] dec_instr_q, dec_instr_d, ex_instr_q, ex_instr_d;
    logic [WORD_W-1:0] pend_instr_q, pend_instr_d, rdata_q, rdata_d;
    handshake_t dhs_q, dhs_d, ehs_q, ehs_d;
    logic ex_valid_q, ex_valid_d, pend_q, pend_d, wr_q, wr_d;
    logic [3:0] cnt_q, cnt_d;
    logic [REG_FIELD_W-1:0] wr_idx_q, wr_idx_d, widx, regidx_q, regidx_d;
    logic [WORD_W-1:0] wval, regdata_q, regdata_d;
    logic we, regw_q, regw_d, adv, shift;

    function automatic handshake_t decode_resp(input logic [WORD_W-1:0] w,
                                               input logic priv_n, input logic busy);
        handshake_t r;
        r = HS_LAST;
        if (w[CLASS_LSB +: CLASS_W] != CLASS_REG_OR_DATA
            || w[COPNUM_LSB +: 4] != COP_NUM)
            r = HS_ABSENT;
        else if (w[XFER_BIT] && w[PRIV_BIT] && !priv_n)
            r = HS_ABSENT;
        else if (busy || (!w[XFER_BIT] && w[LONG_BIT]))
            r = HS_WAIT;
        return r;
    endfunction

    function automatic logic [REG_FIELD_W-1:0] fld(input logic [WORD_W-1:0] w, input int lsb);
        return w[lsb +: REG_FIELD_W];
    endfunction

    assign adv = port.pipeline_advance_enable;
    assign shift = adv && !port.cop_fetch_strobe_n;

    always_comb
    begin
        dec_instr_d = dec_instr_q;
        dhs_d = dhs_q;
        ex_valid_d = ex_valid_q;
        ex_instr_d = ex_instr_q;
        ehs_d = ehs_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        pend_instr_d = pend_instr_q;
        wr_d = wr_q;
        wr_idx_d = wr_idx_q;
        rdata_d = rdata_q;
        we = 1'b0;
        widx = '0;
        wval = '0;
        if (adv)
        begin
            pend_d = 1'b0;
            wr_d = 1'b0;
            if (shift)
                dec_instr_d = port.cop_instruction_bus;
            // Recomputed every advancing cycle so a privilege change updates the answer
            dhs_d = decode_resp(dec_instr_d, port.privilege_indication_n, COP_BUSY);
            // Nothing changes until pass is seen with a wait or last answer
            if (shift && port.cop_condition_pass && dhs_q == HS_LAST)
            begin
                pend_d = 1'b1;
                pend_instr_d = dec_instr_q;
            end
            else if (shift && port.cop_condition_pass && dhs_q == HS_WAIT)
            begin
                ex_valid_d = 1'b1;
                ex_instr_d = dec_instr_q;
                cnt_d = dec_instr_q[LONG_BIT] && !dec_instr_q[XFER_BIT]
                    ? 4'(LONG_WAITS - 1) : 4'h0;
                ehs_d = (cnt_d == 4'h0 && !COP_BUSY) ? HS_LAST : HS_WAIT;
            end
            if (ex_valid_q)
            begin
                if (!port.cop_condition_pass)
                begin
                    ex_valid_d = 1'b0;
                    ehs_d = HS_ABSENT;
                end
                else if (ehs_q == HS_LAST)
                begin
                    ex_valid_d = 1'b0;
                    ehs_d = HS_ABSENT;
                    pend_d = 1'b1;
                    pend_instr_d = ex_instr_q;
                end
                else
                begin
                    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
                    ehs_d = (cnt_d == 4'h0 && !COP_BUSY) ? HS_LAST : HS_WAIT;
                end
            end
            if (pend_d && pend_instr_d[XFER_BIT] && pend_instr_d[LOAD_BIT])
                rdata_d = regs_q[fld(pend_instr_d, CRN_LSB)];
            // A late cancel drops the pending operation before any state moves
            if (pend_q && !port.cop_late_cancel)
            begin
                if (!pend_instr_q[XFER_BIT])
                begin
                    we = 1'b1;
                    widx = fld(pend_instr_q, CRD_LSB);
                    wval = regs_q[fld(pend_instr_q, CRN_LSB)]
                        + regs_q[fld(pend_instr_q, CRM_LSB)];
                end
                else if (!pend_instr_q[LOAD_BIT])
                begin
                    wr_d = 1'b1;
                    wr_idx_d = fld(pend_instr_q, CRN_LSB);
                end
            end
            if (wr_q)
            begin
                we = 1'b1;
                widx = wr_idx_q;
                wval = port.cop_write_data;
            end
        end
        regw_d = we;
        regidx_d = we ? widx : regidx_q;
        regdata_d = we ? wval : regdata_q;
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            dec_instr_q <= '0;
            dhs_q <= HS_ABSENT;
            ex_valid_q <= 1'b0;
            ex_instr_q <= '0;
            ehs_q <= HS_ABSENT;
            cnt_q <= 4'h0;
            pend_q <= 1'b0;
            pend_instr_q <= '0;
            wr_q <= 1'b0;
            wr_idx_q <= '0;
            rdata_q <= '0;
            regw_q <= 1'b0;
            regidx_q <= '0;
            regdata_q <= '0;
        end
        else
        begin
            dec_instr_q <= dec_instr_d;
            dhs_q <= dhs_d;
            ex_valid_q <= ex_valid_d;
            ex_instr_q <= ex_instr_d;
            ehs_q <= ehs_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            pend_instr_q <= pend_instr_d;
            wr_q <= wr_d;
            wr_idx_q <= wr_idx_d;
            rdata_q <= rdata_d;
            regw_q <= regw_d;
            regidx_q <= regidx_d;
            regdata_q <= regdata_d;
        end
    end

    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_reg
        always_ff @(posedge CORE_CLK or posedge RESET)
        begin
            if (RESET)
                regs_q[i] <= '0;
            else if (we && widx == REG_FIELD_W'(i))
                regs_q[i] <= wval;
        end
    end

    assign port.decode_handshake = dhs_q;
    assign port.execute_handshake = ehs_q;
    assign port.cop_read_data = rdata_q;
    assign REG_WRITE = regw_q;
    assign REG_INDEX = regidx_q;
    assign REG_DATA = regdata_q;

endmodule

// ### hdl/cop_issue_end.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Several coprocessors merge handshakes: AND high, OR low
// - Strobe low marks instruction word entering decode
// - Next strobe low issues; pass high, sample decode answer
// - Later execute cycles sample execute answer; commit on last
// - Transfer to coprocessor drives write data in write stage
// - Read data sampled end of memory, written next cycle
// - Missing source data interlocks; coprocessor holds decode
// - Data operation is one execute cycle, pass when executed; here long or busy ones wait for more cycles
// - Late cancel terminates data operation, no state change
// - Coprocessor tracks privilege, may refuse user instructions
// - Only the decode answer at issue counts
// - Coprocessor stalls with wait answers as long as needed
// - Interrupt during busy execute also raises late cancel; here only in the first execute cycle, later pass just drops
// - Handshake codes: 10 absent, 00 wait, 01 go, 11 last
// - No coprocessor fitted ties both answers to absent
// - Late cancel only the cycle after first execute
// - Coprocessor commits only on pass with go or last
module cop_issue_end
    import cop_port_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Instruction issue from the core
    input wire logic ISSUE_VALID,
    input wire logic [WORD_W-1:0] ISSUE_INSTR,
    input wire logic ISSUE_COND_PASS,
    output logic ISSUE_READY,
    // Source operand for transfers to the coprocessor
    input wire logic [WORD_W-1:0] SRC_DATA,
    input wire logic SRC_READY,
    // Core status
    input wire logic PRIVILEGED,
    input wire logic STALL,
    input wire logic INTERRUPT,
    input wire logic DATA_ABORT,
    // Completion
    output logic DONE,
    output result_t DONE_STATUS,
    output logic DEST_WRITE,
    output logic [WORD_W-1:0] DEST_DATA,
    // Coprocessor port
    cop_port_if.device port
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEC = 3'h1,
        ST_EXEC = 3'h2,
        ST_BUSY = 3'h3,
        ST_MEM = 3'h4,
        ST_WRITE = 3'h5,
        ST_DROP = 3'h6
    } state_t;

    state_t state_q, state_d;
    result_t status_q, status_d, result_q, result_d;
    logic [WORD_W-1:0] instr_q, instr_d, bus_q, bus_d, src_q, src_d;
    logic [WORD_W-1:0] wdata_q, wdata_d, ddata_q, ddata_d;
    logic cond_q, cond_d, strobe_n_q, strobe_n_d, pass_q, pass_d;
    logic late_q, late_d, priv_n_q, priv_n_d, adv_q, adv_d;
    logic ready_q, ready_d, done_q, done_d, dwrite_q, dwrite_d;
    logic is_xfer, is_mcr, is_mrc;

    assign is_xfer = instr_q[XFER_BIT];
    assign is_mcr = is_xfer && !instr_q[LOAD_BIT];
    assign is_mrc = is_xfer && instr_q[LOAD_BIT];

    always_comb
    begin
        state_d = state_q;
        status_d = status_q;
        result_d = result_q;
        instr_d = instr_q;
        bus_d = bus_q;
        src_d = src_q;
        wdata_d = wdata_q;
        ddata_d = ddata_q;
        cond_d = cond_q;
        strobe_n_d = strobe_n_q;
        pass_d = pass_q;
        late_d = late_q;
        done_d = 1'b0;
        dwrite_d = 1'b0;
        adv_d = !STALL;
        priv_n_d = PRIVILEGED;
        // The sequencer freezes while the advance enable on the port is low, though privilege
        // and ready keep tracking, so the follower and this end always step together
        if (adv_q)
        begin
            late_d = 1'b0;
            strobe_n_d = 1'b1;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (ready_q && ISSUE_VALID)
                    begin
                        instr_d = ISSUE_INSTR;
                        cond_d = ISSUE_COND_PASS;
                        bus_d = ISSUE_INSTR;
                        strobe_n_d = 1'b0;
                        state_d = ST_DEC;
                    end
                end
                ST_DEC:
                begin
                    // Stay in decode with strobe high until the operand exists
                    if (!(is_mcr && !SRC_READY))
                    begin
                        strobe_n_d = 1'b0;
                        bus_d = '0;
                        pass_d = cond_q;
                        src_d = SRC_DATA;
                        state_d = ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    pass_d = 1'b0;
                    if (!pass_q)
                    begin
                        // Failed condition: the decode answer is ignored
                        status_d = RES_SKIPPED;
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                    else if (DATA_ABORT)
                    begin
                        late_d = 1'b1;
                        result_d = RES_CANCEL;
                        state_d = ST_DROP;
                    end
                    else
                    begin
                        unique case (port.decode_handshake)
                            HS_ABSENT:
                            begin
                                status_d = RES_UNDEF;
                                done_d = 1'b1;
                                state_d = ST_IDLE;
                            end
                            HS_WAIT:
                            begin
                                if (INTERRUPT)
                                begin
                                    late_d = 1'b1;
                                    result_d = RES_ABANDON;
                                    state_d = ST_DROP;
                                end
                                else
                                begin
                                    pass_d = 1'b1;
                                    state_d = ST_BUSY;
                                end
                            end
                            HS_GO:
                            begin
                                pass_d = 1'b1;
                                state_d = ST_BUSY;
                            end
                            HS_LAST:
                                state_d = ST_MEM;
                        endcase
                    end
                end
                ST_BUSY:
                begin
                    if (INTERRUPT && port.execute_handshake == HS_WAIT)
                    begin
                        // Pass drops so the follower abandons; a last answer already committed
                        pass_d = 1'b0;
                        result_d = RES_ABANDON;
                        state_d = ST_DROP;
                    end
                    else
                    begin
                        unique case (port.execute_handshake)
                            HS_ABSENT:
                            begin
                                pass_d = 1'b0;
                                status_d = RES_UNDEF;
                                done_d = 1'b1;
                                state_d = ST_IDLE;
                            end
                            HS_LAST:
                            begin
                                pass_d = 1'b0;
                                state_d = ST_MEM;
                            end
                            HS_WAIT, HS_GO:
                                state_d = ST_BUSY;
                        endcase
                    end
                end
                ST_MEM:
                begin
                    if (is_mrc)
                    begin
                        ddata_d = port.cop_read_data;
                        dwrite_d = 1'b1;
                    end
                    if (is_mcr)
                        wdata_d = src_q;
                    state_d = ST_WRITE;
                end
                ST_WRITE:
                begin
                    status_d = RES_COMMIT;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
                ST_DROP:
                begin
                    pass_d = 1'b0;
                    status_d = result_q;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
                default:
                    state_d = ST_IDLE;
            endcase
        end
        ready_d = (state_d == ST_IDLE) && !STALL;
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_q <= ST_IDLE;
            status_q <= RES_COMMIT;
            result_q <= RES_COMMIT;
            instr_q <= '0;
            bus_q <= '0;
            src_q <= '0;
            wdata_q <= '0;
            ddata_q <= '0;
            cond_q <= 1'b0;
            strobe_n_q <= STROBE_N_RESET;
            pass_q <= 1'b0;
            late_q <= 1'b0;
            priv_n_q <= PRIV_N_RESET;
            adv_q <= ADVANCE_RESET;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            dwrite_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            status_q <= status_d;
            result_q <= result_d;
            instr_q <= instr_d;
            bus_q <= bus_d;
            src_q <= src_d;
            wdata_q <= wdata_d;
            ddata_q <= ddata_d;
            cond_q <= cond_d;
            strobe_n_q <= strobe_n_d;
            pass_q <= pass_d;
            late_q <= late_d;
            priv_n_q <= priv_n_d;
            adv_q <= adv_d;
            ready_q <= ready_d;
            done_q <= done_d;
            dwrite_q <= dwrite_d;
        end
    end

    assign port.cop_fetch_strobe_n = strobe_n_q;
    assign port.cop_instruction_bus = bus_q;
    assign port.cop_condition_pass = pass_q;
    assign port.cop_late_cancel = late_q;
    assign port.cop_write_data = wdata_q;
    assign port.privilege_indication_n = priv_n_q;
    assign port.pipeline_advance_enable = adv_q;
    assign ISSUE_READY = ready_q;
    assign DONE = done_q;
    assign DONE_STATUS = status_q;
    assign DEST_WRITE = dwrite_q;
    assign DEST_DATA = ddata_q;

endmodule

// ### pkg/cop_port_if.sv
`timescale 1ns/10ps
interface cop_port_if;
    import cop_port_pkg::*;

    logic cop_fetch_strobe_n;
    logic [WORD_W-1:0] cop_instruction_bus;
    logic cop_condition_pass;
    logic cop_late_cancel;
    logic [WORD_W-1:0] cop_write_data;
    logic privilege_indication_n;
    logic pipeline_advance_enable;
    handshake_t decode_handshake;
    handshake_t execute_handshake;
    logic [WORD_W-1:0] cop_read_data;

    modport device (
        output cop_fetch_strobe_n,
        output cop_instruction_bus,
        output cop_condition_pass,
        output cop_late_cancel,
        output cop_write_data,
        output privilege_indication_n,
        output pipeline_advance_enable,
        input decode_handshake,
        input execute_handshake,
        input cop_read_data
    );

    modport coproc (
        input cop_fetch_strobe_n,
        input cop_instruction_bus,
        input cop_condition_pass,
        input cop_late_cancel,
        input cop_write_data,
        input privilege_indication_n,
        input pipeline_advance_enable,
        output decode_handshake,
        output execute_handshake,
        output cop_read_data
    );

endinterface

// ### pkg/cop_port_pkg.sv
package cop_port_pkg;

    // Handshake codes shared by the decode and execute buses
    typedef enum logic [1:0] {
        HS_WAIT = 2'h0,
        HS_GO = 2'h1,
        HS_ABSENT = 2'h2,
        HS_LAST = 2'h3
    } handshake_t;

    // Outcome of one coprocessor instruction as seen by the core
    typedef enum logic [2:0] {
        RES_COMMIT = 3'h0,
        RES_SKIPPED = 3'h1,
        RES_UNDEF = 3'h2,
        RES_ABANDON = 3'h3,
        RES_CANCEL = 3'h4
    } result_t;

    localparam int WORD_W = 32;
    localparam int REG_FIELD_W = 4;

    // Instruction word fields
    localparam int CLASS_LSB = 24;
    localparam int CLASS_W = 4;
    localparam logic [3:0] CLASS_REG_OR_DATA = 4'hE;
    localparam int XFER_BIT = 4;
    localparam int LOAD_BIT = 20;
    localparam int PRIV_BIT = 5;
    localparam int LONG_BIT = 21;
    localparam int COPNUM_LSB = 8;
    localparam int CRN_LSB = 16;
    localparam int CRD_LSB = 12;
    localparam int CRM_LSB = 0;

    // Reset values
    localparam logic STROBE_N_RESET = 1'h1;
    localparam logic PRIV_N_RESET = 1'h1;
    localparam logic ADVANCE_RESET = 1'h0;

    // Timing counts and default coprocessor number
    localparam int LONG_OP_WAITS = 3;
    localparam logic [3:0] DEFAULT_COP_NUM = 4'h5;

endpackage

// ### verif/coprocessor_handshake_port_chk.sv
`timescale 1ns/10ps
module coprocessor_handshake_port_chk
    import cop_port_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Port signals
    input wire logic cop_fetch_strobe_n,
    input wire logic cop_condition_pass,
    input wire logic cop_late_cancel,
    input wire logic pipeline_advance_enable,
    input wire handshake_t decode_handshake,
    input wire handshake_t execute_handshake
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);

    reset_quiet_a: assert property ($past(RESET) |->
        cop_fetch_strobe_n && !cop_late_cancel)
        else $error("strobe or cancel active right after reset");
    hs_absent_a: assert property ($past(RESET) |->
        decode_handshake == HS_ABSENT && execute_handshake == HS_ABSENT)
        else $error("follower not absent after reset");
    pass_issue_a: assert property ($rose(cop_condition_pass) |-> !cop_fetch_strobe_n)
        else $error("pass raised without issue strobe");
    late_once_a: assert property (cop_late_cancel && pipeline_advance_enable
        |=> !cop_late_cancel)
        else $error("late cancel longer than one cycle");
    late_nopass_a: assert property (cop_late_cancel |->
        !cop_condition_pass && $past(cop_condition_pass))
        else $error("late cancel not right after execute");
    dec_last_a: assert property (pipeline_advance_enable && decode_handshake == HS_LAST
        && cop_condition_pass && !$past(cop_condition_pass) |=> !cop_condition_pass)
        else $error("pass held after decode last");
    dec_wait_a: assert property (pipeline_advance_enable && decode_handshake == HS_WAIT
        && cop_condition_pass && !$past(cop_condition_pass)
        |=> cop_condition_pass || cop_late_cancel)
        else $error("busy wait dropped without cause");
    ex_last_a: assert property (pipeline_advance_enable && execute_handshake == HS_LAST
        && cop_condition_pass && $past(cop_condition_pass) |=> !cop_condition_pass)
        else $error("pass held after execute last");

    cover property (cop_late_cancel);
    cover property (cop_condition_pass && decode_handshake == HS_WAIT);
    cover property (cop_condition_pass && execute_handshake == HS_LAST);
endmodule

// ### verif/coprocessor_handshake_port_tb.sv
`timescale 1ns/10ps
module coprocessor_handshake_port_tb;
    import cop_port_pkg::*;
    `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
        $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
    localparam logic [WORD_W-1:0] BASE = 32'h0E000500;
    logic clk = 0, rst = 1, valid = 0, cond = 1, srdy = 1, priv = 1, stall = 0;
    logic irq = 0, abort = 0, busy = 0, ready, done, dest_wr, reg_wr;
    logic [WORD_W-1:0] instr = '0, src = '0, dest_data, reg_data, last_data;
    logic [REG_FIELD_W-1:0] reg_idx, last_idx;
    result_t status;
    int error_cnt = 0, comparisons = 0, late_seen = 0, dest_seen = 0;

    cop_port_if cop_port_if_inst ();
    cop_issue_end cop_issue_end_inst (.CORE_CLK(clk), .RESET(rst), .ISSUE_VALID(valid),
        .ISSUE_INSTR(instr), .ISSUE_COND_PASS(cond), .ISSUE_READY(ready), .SRC_DATA(src),
        .SRC_READY(srdy), .PRIVILEGED(priv), .STALL(stall), .INTERRUPT(irq),
        .DATA_ABORT(abort), .DONE(done), .DONE_STATUS(status), .DEST_WRITE(dest_wr),
        .DEST_DATA(dest_data), .port(cop_port_if_inst.device));
    cop_follower_end cop_follower_end_inst (.CORE_CLK(clk), .RESET(rst),
        .port(cop_port_if_inst.coproc), .COP_BUSY(busy), .REG_WRITE(reg_wr),
        .REG_INDEX(reg_idx), .REG_DATA(reg_data));
    coprocessor_handshake_port_chk coprocessor_handshake_port_chk_inst (.CORE_CLK(clk),
        .RESET(rst), .cop_fetch_strobe_n(cop_port_if_inst.cop_fetch_strobe_n),
        .cop_condition_pass(cop_port_if_inst.cop_condition_pass),
        .cop_late_cancel(cop_port_if_inst.cop_late_cancel),
        .pipeline_advance_enable(cop_port_if_inst.pipeline_advance_enable),
        .decode_handshake(cop_port_if_inst.decode_handshake),
        .execute_handshake(cop_port_if_inst.execute_handshake));

    initial
    begin
        forever #2 clk = ~clk;
    end

    // Committed writes and cancels are caught here since both are single-cycle pulses
    always @(posedge clk)
    begin
        if (reg_wr === 1'b1)
        begin
            last_idx <= reg_idx;
            last_data <= reg_data;
        end
        if (cop_port_if_inst.cop_late_cancel === 1'b1)
            late_seen++;
        if (dest_wr === 1'b1)
            dest_seen++;
    end

    function automatic logic [WORD_W-1:0] xfer(input logic [3:0] r, input logic ld);
        return BASE | 32'h10 | {11'h0, ld, r, 16'h0};
    endfunction

    function automatic logic [WORD_W-1:0] cop_data_operation(input logic [3:0] d, n, m);
        return BASE | {12'h0, n, d, 8'h0, m};
    endfunction

    // Handshake of two coprocessors joined by system glue
    function automatic handshake_t merge(input handshake_t a, b);
        return handshake_t'({a[1] & b[1], a[0] | b[0]});
    endfunction

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Done is a pulse, so polling starts after the source and interrupt delays, which end before it rises
    task automatic run(input logic [WORD_W-1:0] ins, input int sdly, idly, input result_t exp);
        repeat (100) if (ready !== 1'b1) @(negedge clk);
        instr = ins;
        valid = 1'b1;
        srdy = (sdly == 0);
        @(negedge clk);
        valid = 1'b0;
        // Stalling during the interlock makes the follower hold its decode stage
        stall = (sdly > 0);
        repeat (sdly) @(negedge clk);
        srdy = 1'b1;
        stall = 1'b0;
        repeat (idly) @(negedge clk);
        if (idly > 0) irq = 1'b1;
        repeat (200) if (done !== 1'b1) @(negedge clk);
        `CHK(done, 1'b1)
        `CHK(status, exp)
        irq = 1'b0;
        abort = 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [3:0] r, input logic [WORD_W-1:0] v, input int dly);
        src = v;
        run(xfer(r, 1'b0), dly, 0, RES_COMMIT);
        `CHK(last_data, v)
    endtask

    task automatic rd(input logic [3:0] r, input logic [WORD_W-1:0] v);
        int n;
        n = dest_seen;
        run(xfer(r, 1'b1), 0, 0, RES_COMMIT);
        `CHK(dest_data, v)
        `CHK(dest_seen, n + 1)
    endtask

    task automatic t_transfer();
        wr(4'h3, 32'hA5C30F1E, 2);
        `CHK(last_idx, 4'h3)
        `CHK(cop_port_if_inst.cop_write_data, 32'hA5C30F1E)
        rd(4'h3, 32'hA5C30F1E);
    endtask

    task automatic t_dataop();
        wr(4'h1, 32'h5, 0);
        wr(4'h2, 32'h7, 0);
        run(cop_data_operation(4'h4, 4'h1, 4'h2), 0, 0, RES_COMMIT);
        rd(4'h4, 32'hC);
        run(cop_data_operation(4'h5, 4'h4, 4'h1) | 32'h200000, 0, 0, RES_COMMIT);
        rd(4'h5, 32'h11);
    endtask

    task automatic t_refused();
        `CHK(merge(HS_WAIT, HS_ABSENT), 2'h0)
        `CHK(merge(HS_LAST, HS_ABSENT), 2'h3)
        cond = 1'b0;
        run(cop_data_operation(4'h6, 4'h1, 4'h2), 0, 0, RES_SKIPPED);
        cond = 1'b1;
        rd(4'h6, 32'h0);
        run(cop_data_operation(4'h1, 4'h1, 4'h1) ^ 32'h300, 0, 0, RES_UNDEF);
        rd(4'h1, 32'h5);
        priv = 1'b0;
        repeat (2) @(negedge clk);
        run(xfer(4'h2, 1'b1) | 32'h20, 0, 0, RES_UNDEF);
        priv = 1'b1;
        repeat (2) @(negedge clk);
        rd(4'h2, 32'h7);
    endtask

    task automatic t_cancel();
        abort = 1'b1;
        run(cop_data_operation(4'h1, 4'h1, 4'h2), 0, 0, RES_CANCEL);
        `CHK(late_seen, 1)
        rd(4'h1, 32'h5);
        busy = 1'b1;
        run(cop_data_operation(4'h1, 4'h1, 4'h2), 0, 4, RES_ABANDON);
        `CHK(late_seen, 1)
        irq = 1'b1;
        run(cop_data_operation(4'h2, 4'h2, 4'h2), 0, 0, RES_ABANDON);
        `CHK(late_seen, 2)
        busy = 1'b0;
        rd(4'h1, 32'h5);
        rd(4'h2, 32'h7);
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_transfer();
        t_dataop();
        t_refused();
        t_cancel();
        wrap_up();
    end

    initial
    begin
        #40000;
        error_cnt++;
        wrap_up();
    end
endmodule
